// File: src/vpc_pkg.sv
/*
 * Holds the constants shared by the voltage PWM chopper scaling block:
 * register offsets, field positions, reset values and chopper periods.
 * Assumes a 32-bit AXI4-Lite register bus and a 100 MHz system clock.
 */
package vpc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [5:0] ADDR_CONFIG = 6'h00;
  localparam logic [5:0] ADDR_COOL_THRS = 6'h04;
  localparam logic [5:0] ADDR_HIGH_THRS = 6'h08;
  localparam logic [5:0] ADDR_STATUS = 6'h0C;
  localparam logic [5:0] ADDR_INT_STATUS = 6'h10;
  localparam logic [5:0] ADDR_INT_MASK = 6'h14;
  localparam int ADDR_W = 6;

  // ---------------------------------------------------------------
  // Field layout of the configuration and status registers
  // ---------------------------------------------------------------
  localparam int CFG_AMP_LSB = 0;
  localparam int CFG_GRAD_LSB = 8;
  localparam int CFG_AUTO_BIT = 12;
  localparam int CFG_FREQ_LSB = 16;
  localparam int STAT_OLA_BIT = 8;
  localparam int STAT_OLB_BIT = 9;
  localparam int STAT_MODE_BIT = 10;
  localparam int STAT_START_BIT = 11;

  localparam int VEL_W = 23;
  localparam logic [22:0] THRS_RESET = 23'h7FFFFF;
  localparam logic [7:0] AMP_RESET = 8'hFF;
  localparam logic [3:0] GRAD_RESET = 4'h0;
  localparam logic [7:0] SCALE_MAX = 8'hFF;

  // Interrupt status bits: open load rise on A, on B, leave, re-entry.
  localparam int INT_W = 4;

  // ---------------------------------------------------------------
  // Chopper period in system clocks per frequency selection
  // ---------------------------------------------------------------
  localparam logic [10:0] PER_0 = 11'd1024;
  localparam logic [10:0] PER_1 = 11'd683;
  localparam logic [10:0] PER_2 = 11'd512;
  localparam logic [10:0] PER_3 = 11'd410;

  // Fullsteps without reaching target before both open load flags rise.
  localparam logic [2:0] FAIL_STEPS = 3'd4;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : vpc_pkg

// File: src/vpc_top.sv
/*
 * Voltage PWM chopper amplitude control: fixed or regulated scale, mode
 * hand-over at the velocity thresholds, open load flags and interrupts.
 * Assumes ramp velocity, target current and fullstep pulses come from logic
 * on clk_i; the coil current comparators come from the power stage pins.
 */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - fixed mode drives scale from user amplitude
// - 8-bit scale, sine peak 248, Vrms=V*s/374
// - lower of cool and high thresholds splits voltage and current chopper
// - hold scale outside voltage mode, resume later
// - open load flags show target unreached per coil
// - open coil keeps its flag continuously set
// - both flags when target unreached several fullsteps
// - fast raise for low coil, slow lowering
// - regulated scale is readable by software
// - gradient zero disables voltage chopping
// - amplitude is fixed value or re-entry limit
// - voltage mode only below lower threshold
// - regulation freezes at zero target current
module vpc_top
  import vpc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [22:0] ramp_velocity_i,
  input wire logic [4:0] target_current_i,
  input wire logic fullstep_i,
  input wire logic coil_a_low_i,
  input wire logic coil_b_low_i,
  input wire logic coil_a_high_i,
  input wire logic coil_b_high_i,
  output logic [7:0] pwm_scale_o,
  output logic voltage_mode_o,
  output logic open_load_coil_a_o,
  output logic open_load_coil_b_o,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  logic [7:0] user_pwm_amplitude;
  logic [3:0] regulation_gradient;
  logic autoscale;
  logic [1:0] pwm_freq;
  logic [22:0] cool_velocity_threshold;
  logic [22:0] high_velocity_threshold;
  logic [INT_W-1:0] int_status;
  logic [INT_W-1:0] int_mask;
  logic [5:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic [10:0] period_cnt;
  logic [7:0] scale;
  logic mode;
  logic started;
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic seen_a_low;
  logic seen_b_low;
  logic seen_high;
  logic low_since_step;
  logic [2:0] fail_cnt;

  // ---------------------------------------------------------------
  // Synchronisers for the coil comparator pins
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end else begin
      sync1 <= {coil_b_high_i, coil_a_high_i, coil_b_low_i, coil_a_low_i};
      sync2 <= sync1;
    end
  end

  // ---------------------------------------------------------------
  // Chopper period and mode decision
  // ---------------------------------------------------------------
  wire [10:0] period_len = (pwm_freq == 2'd0) ? PER_0 :
                           (pwm_freq == 2'd1) ? PER_1 :
                           (pwm_freq == 2'd2) ? PER_2 : PER_3;
  wire period_end = (period_cnt >= period_len - 11'd1);
  wire below_lower = (ramp_velocity_i < cool_velocity_threshold) &&
                     (ramp_velocity_i < high_velocity_threshold);
  wire next_mode = (regulation_gradient != GRAD_RESET) && below_lower;
  wire entering = next_mode && !mode;
  wire leaving = !next_mode && mode;
  wire standstill = (ramp_velocity_i == '0);
  wire target_zero = (target_current_i == '0);

  // ---------------------------------------------------------------
  // Scale regulation
  // ---------------------------------------------------------------
  wire any_low = seen_a_low || seen_b_low;
  wire [3:0] down_half = {1'b0, regulation_gradient[3:1]};
  wire [3:0] down_step = (down_half == 4'h0) ? 4'h1 : down_half;
  wire [8:0] scale_up = {1'b0, scale} + {5'h00, regulation_gradient};
  wire [7:0] scale_inc = scale_up[8] ? SCALE_MAX : scale_up[7:0];
  wire [7:0] scale_dec = (scale > {4'h0, down_step}) ?
                         scale - {4'h0, down_step} : 8'h00;
  wire [7:0] reentry = (scale < user_pwm_amplitude) ? scale :
                       user_pwm_amplitude;
  wire may_regulate = (started || standstill) && !target_zero;
  wire [7:0] regulated = !may_regulate ? scale :
                         any_low ? scale_inc :
                         seen_high ? scale_dec : scale;
  wire [7:0] next_scale = !autoscale ? user_pwm_amplitude :
                          !period_end ? scale :
                          entering ? reentry :
                          (next_mode && mode) ? regulated : scale;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      period_cnt <= '0;
      mode <= 1'b0;
      scale <= '0;
      started <= 1'b0;
    end else begin
      period_cnt <= period_end ? '0 : period_cnt + 11'd1;
      if (period_end) begin
        mode <= next_mode;
      end
      scale <= next_scale;
      if (regulation_gradient == GRAD_RESET || !autoscale) begin
        started <= 1'b0;
      end else if (period_end && mode && standstill && !target_zero) begin
        started <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Per-period current observation and open load flags
  // ---------------------------------------------------------------
  wire fail_full = (fail_cnt >= FAIL_STEPS);
  wire active = mode && autoscale;
  // Flags drop with the mode, so none outlives voltage mode by a period.
  wire flag_on = active && next_mode;
  wire next_ola = flag_on && (seen_a_low || fail_full);
  wire next_olb = flag_on && (seen_b_low || fail_full);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      seen_a_low <= 1'b0;
      seen_b_low <= 1'b0;
      seen_high <= 1'b0;
      low_since_step <= 1'b0;
      fail_cnt <= '0;
    end else begin
      seen_a_low <= period_end ? 1'b0 : (seen_a_low || sync2[0]);
      seen_b_low <= period_end ? 1'b0 : (seen_b_low || sync2[1]);
      seen_high <= period_end ? 1'b0 :
                   (seen_high || sync2[2] || sync2[3]);
      if (fullstep_i) begin
        low_since_step <= 1'b0;
        if (!active || !low_since_step) begin
          fail_cnt <= '0;
        end else if (!fail_full) begin
          fail_cnt <= fail_cnt + 3'd1;
        end
      end else if (period_end && any_low) begin
        low_since_step <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire wr_cfg = do_write && (aw_addr == ADDR_CONFIG);
  wire wr_cool = do_write && (aw_addr == ADDR_COOL_THRS);
  wire wr_high = do_write && (aw_addr == ADDR_HIGH_THRS);
  wire wr_ist = do_write && (aw_addr == ADDR_INT_STATUS);
  wire wr_imask = do_write && (aw_addr == ADDR_INT_MASK);
  wire wr_hit = wr_cfg || wr_cool || wr_high || wr_ist || wr_imask ||
                (aw_addr == ADDR_STATUS);
  wire [31:0] bmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                       {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] cfg_word = {14'h0, pwm_freq, 3'h0, autoscale,
                          regulation_gradient, user_pwm_amplitude};
  wire [31:0] cfg_new = (cfg_word & ~bmask) | (w_data & bmask);
  wire [31:0] cool_new = ({9'h0, cool_velocity_threshold} & ~bmask) |
                         (w_data & bmask);
  wire [31:0] high_new = ({9'h0, high_velocity_threshold} & ~bmask) |
                         (w_data & bmask);
  wire [31:0] stat_word = {20'h0, started, mode, open_load_coil_b_o,
                           open_load_coil_a_o, scale};
  wire [31:0] rd_word =
    (s_axi_araddr == ADDR_CONFIG) ? cfg_word :
    (s_axi_araddr == ADDR_COOL_THRS) ? {9'h0, cool_velocity_threshold} :
    (s_axi_araddr == ADDR_HIGH_THRS) ? {9'h0, high_velocity_threshold} :
    (s_axi_araddr == ADDR_STATUS) ? stat_word :
    (s_axi_araddr == ADDR_INT_STATUS) ? {28'h0, int_status} :
    (s_axi_araddr == ADDR_INT_MASK) ? {28'h0, int_mask} : 32'h0;
  wire rd_hit = (s_axi_araddr == ADDR_CONFIG) ||
                (s_axi_araddr == ADDR_COOL_THRS) ||
                (s_axi_araddr == ADDR_HIGH_THRS) ||
                (s_axi_araddr == ADDR_STATUS) ||
                (s_axi_araddr == ADDR_INT_STATUS) ||
                (s_axi_araddr == ADDR_INT_MASK);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[5:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Configuration and interrupt registers
  // ---------------------------------------------------------------
  wire [INT_W-1:0] int_event = {
    period_end && entering,
    period_end && leaving,
    next_olb && !open_load_coil_b_o,
    next_ola && !open_load_coil_a_o};
  wire [INT_W-1:0] int_clear = wr_ist ? (w_data[INT_W-1:0] &
                               {INT_W{w_strb[0]}}) : '0;
  // A new event wins over a clear in the same cycle.
  wire [INT_W-1:0] next_int = (int_status & ~int_clear) | int_event;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      user_pwm_amplitude <= AMP_RESET;
      regulation_gradient <= GRAD_RESET;
      autoscale <= 1'b0;
      pwm_freq <= 2'd0;
      cool_velocity_threshold <= THRS_RESET;
      high_velocity_threshold <= THRS_RESET;
      int_status <= '0;
      int_mask <= '0;
      irq_o <= 1'b0;
      pwm_scale_o <= '0;
      voltage_mode_o <= 1'b0;
      open_load_coil_a_o <= 1'b0;
      open_load_coil_b_o <= 1'b0;
    end else begin
      if (wr_cfg) begin
        user_pwm_amplitude <= cfg_new[CFG_AMP_LSB +: 8];
        regulation_gradient <= cfg_new[CFG_GRAD_LSB +: 4];
        autoscale <= cfg_new[CFG_AUTO_BIT];
        pwm_freq <= cfg_new[CFG_FREQ_LSB +: 2];
      end
      if (wr_cool) begin
        cool_velocity_threshold <= cool_new[VEL_W-1:0];
      end
      if (wr_high) begin
        high_velocity_threshold <= high_new[VEL_W-1:0];
      end
      if (wr_imask) begin
        int_mask <= (int_mask & ~bmask[INT_W-1:0]) |
                    (w_data[INT_W-1:0] & bmask[INT_W-1:0]);
      end
      int_status <= next_int;
      irq_o <= |(next_int & int_mask);
      pwm_scale_o <= next_scale;
      if (period_end) begin
        voltage_mode_o <= next_mode;
        open_load_coil_a_o <= next_ola;
        open_load_coil_b_o <= next_olb;
      end
    end
  end

endmodule : vpc_top

`default_nettype wire

// File: dv/vpc_top_assertions.sv
/* Port checker for vpc_top.
   Assumes it is bound onto vpc_top with one clock and reset. */
`timescale 1ns/1ps
`default_nettype none
module vpc_top_assertions (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic voltage_mode_o,
  input wire logic open_load_coil_a_o,
  input wire logic open_load_coil_b_o
);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic mode_q;
  logic [8:0] since;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_q <= 1'b0;
      since <= 9'h000;
    end else begin
      mode_q <= voltage_mode_o;
      since <= (voltage_mode_o != mode_q) ? 9'h000 : since + {8'h00, ~&since};
    end
  end
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    !s_axi_awready ##1 s_axi_bvalid;
  endsequence
  a_write_answer: assert property (s_wr_taken |=> s_wr_answer)
    else $error("write response missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("read answer missing");
  a_resp_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_write_refused: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  a_resp_code: assert property (s_axi_bvalid
    |-> s_axi_bresp inside {2'h0, 2'h2}) else $error("bad bresp");
  a_ola_mode: assert property (open_load_coil_a_o |-> voltage_mode_o)
    else $error("coil a flag outside voltage mode");
  a_olb_mode: assert property (open_load_coil_b_o |-> voltage_mode_o)
    else $error("coil b flag outside voltage mode");
  a_mode_spacing: assert property ($changed(voltage_mode_o)
    |-> since >= 400) else $error("mode changed inside a period");
endmodule : vpc_top_assertions
bind vpc_top vpc_top_assertions u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .voltage_mode_o(voltage_mode_o), .open_load_coil_a_o(open_load_coil_a_o),
  .open_load_coil_b_o(open_load_coil_b_o));
`default_nettype wire

// File: dv/vpc_coil_model.sv
/* Behavioural model of two coils and their current comparators.
   Assumes coil current follows the PWM scale against a needed scale. */
`timescale 1ns/1ps
`default_nettype none
module vpc_coil_model (
  input wire logic [7:0] pwm_scale_i,
  input wire logic [7:0] need_i,
  input wire logic open_a_i,
  output logic a_low_o,
  output logic b_low_o,
  output logic a_high_o,
  output logic b_high_o
);
  // An open coil never reaches its current and never exceeds it.
  assign a_low_o = open_a_i || (pwm_scale_i < need_i);
  assign a_high_o = !open_a_i && (pwm_scale_i > need_i);
  assign b_low_o = pwm_scale_i < need_i;
  assign b_high_o = pwm_scale_i > need_i;
endmodule : vpc_coil_model
`default_nettype wire

// File: dv/vpc_top_tb.sv
/* Register-level testbench of vpc_top with a coil model.
   Assumes the highest chopper frequency, 410 clocks a period. */
`timescale 1ns/1ps
`default_nettype none
module vpc_top_tb
  import vpc_pkg::*;
;
  localparam int PER = 410;
  logic clk_i = 1'b0, rstn_i = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0;
  logic arv = 1'b0, rry = 1'b0, fs = 1'b0, open_a = 1'b0;
  logic [5:0] awa = 6'h00, ara = 6'h00;
  logic [31:0] wd = 32'h0, rd, last;
  logic [22:0] vel = 23'h0;
  logic [4:0] tgt = 5'h00;
  logic [7:0] need = 8'h60, scale;
  logic awr, wrd, bv, arr, rv, irq, mode, open_load_coil_a, open_load_coil_b, cal, cbl, cah, cbh;
  logic [1:0] br, rr;
  int error_cnt = 0, n_checks = 0, t;
  logic [7:0] scale_q;
  logic mode_q, ola_q, olb_q, irq_q;
  always #5 clk_i = ~clk_i;
  // Outputs are copied at the falling edge, so checks see settled values.
  always @(negedge clk_i) begin
    scale_q <= scale;
    mode_q <= mode;
    ola_q <= open_load_coil_a;
    olb_q <= open_load_coil_b;
    irq_q <= irq;
  end
  vpc_top DUT (.clk_i(clk_i), .rstn_i(rstn_i), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .ramp_velocity_i(vel), .target_current_i(tgt),
    .fullstep_i(fs), .coil_a_low_i(cal), .coil_b_low_i(cbl),
    .coil_a_high_i(cah), .coil_b_high_i(cbh), .pwm_scale_o(scale),
    .voltage_mode_o(mode), .open_load_coil_a_o(open_load_coil_a),
    .open_load_coil_b_o(open_load_coil_b), .irq_o(irq));
  vpc_coil_model u_coil (.pwm_scale_i(scale), .need_i(need),
    .open_a_i(open_a), .a_low_o(cal), .b_low_o(cbl), .a_high_o(cah),
    .b_high_o(cbh));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    n_checks++;
    if (seen !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, seen);
    end
  endtask : chk
  task tick(input int n);
    if (++t > 50) begin
      error_cnt++;
      print_verdict();
    end
  endtask : tick
  task wchk(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_hs, w_hs, b_hs;
    logic [1:0] resp;
    t = 0;
    @(posedge clk_i);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      // Values at the falling edge are those the next rising edge samples.
      @(negedge clk_i);
      aw_hs = awv && awr;
      w_hs = wv && wrd;
      b_hs = bv;
      resp = br;
      @(posedge clk_i);
      if (aw_hs) awv <= 1'b0;
      if (w_hs) wv <= 1'b0;
      tick(1);
    end while (!b_hs);
    bry <= 1'b0;
    chk("bresp", resp, er);
  endtask : wchk
  task rchk(input string nm, input logic [5:0] a, input logic [31:0] e,
            input logic [31:0] m, input logic [1:0] er);
    logic ar_hs, r_hs;
    logic [31:0] rdat;
    logic [1:0] resp;
    t = 0;
    @(posedge clk_i);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(negedge clk_i);
      ar_hs = arv && arr;
      r_hs = rv;
      rdat = rd;
      resp = rr;
      @(posedge clk_i);
      if (ar_hs) arv <= 1'b0;
      tick(1);
    end while (!r_hs);
    rry <= 1'b0;
    last = rdat;
    chk(nm, rdat & m, e);
    chk("rresp", resp, er);
  endtask : rchk
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    cyc(10);
    rstn_i <= 1'b1;
    rchk("config", ADDR_CONFIG, 32'h000000FF, 32'hFFFFFFFF, RESP_OKAY);
    wchk(ADDR_CONFIG, 32'h00030040, RESP_OKAY);
    rchk("cool", ADDR_COOL_THRS, 32'h007FFFFF, 32'hFFFFFFFF, RESP_OKAY);
    rchk("status", ADDR_STATUS, 32'h0, 32'hFFFFFF00, RESP_OKAY);
    rchk("unmapped", 6'h18, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    wchk(6'h18, 32'h1, RESP_SLVERR);
    wchk(ADDR_INT_MASK, 32'hF, RESP_OKAY);
    cyc(2 * PER);
    chk("fixed scale", scale_q, 32'h40);
    chk("grad zero", mode_q, 32'h0);
    vel <= 23'h32;
    wchk(ADDR_CONFIG, 32'h00030440, RESP_OKAY);
    cyc(2 * PER);
    chk("voltage only", mode_q, 32'h1);
    wchk(ADDR_COOL_THRS, 32'h64, RESP_OKAY);
    wchk(ADDR_HIGH_THRS, 32'h32, RESP_OKAY);
    cyc(2 * PER);
    chk("at high", mode_q, 32'h0);
    wchk(ADDR_INT_STATUS, 32'hF, RESP_OKAY);
    vel <= 23'h31;
    cyc(2 * PER);
    chk("below both", mode_q, 32'h1);
    chk("irq entry", irq_q, 32'h1);
    rchk("int", ADDR_INT_STATUS, 32'h8, 32'hF, RESP_OKAY);
    wchk(ADDR_INT_STATUS, 32'h8, RESP_OKAY);
    cyc(3);
    chk("irq cleared", irq_q, 32'h0);
    vel <= 23'h0;
    tgt <= 5'h08;
    wchk(ADDR_CONFIG, 32'h000314FF, RESP_OKAY);
    cyc(128 * PER);
    rchk("status", ADDR_STATUS, 32'hC00, 32'hC00, RESP_OKAY);
    chk("regulated", last[7:0] inside {[8'h5A:8'h66]}, 32'h1);
    vel <= 23'hC8;
    cyc(3 * PER);
    chk("left", mode_q, 32'h0);
    chk("held", scale_q inside {[8'h5A:8'h66]}, 32'h1);
    wchk(ADDR_INT_STATUS, 32'hF, RESP_OKAY);
    wchk(ADDR_CONFIG, 32'h00031450, RESP_OKAY);
    tgt <= 5'h00;
    vel <= 23'h0;
    t = 0;
    while (!mode_q && t < 3 * PER) begin
      @(posedge clk_i);
      t++;
    end
    chk("reentered", mode_q, 32'h1);
    chk("reentry limit", scale_q, 32'h50);
    need <= 8'h10;
    cyc(3 * PER);
    chk("frozen", scale_q, 32'h50);
    tgt <= 5'h08;
    cyc(3 * PER);
    chk("lowered", scale_q < 8'h50, 32'h1);
    need <= 8'h30;
    open_a <= 1'b1;
    cyc(2 * PER);
    t = 0;
    repeat (2 * PER) begin
      @(posedge clk_i);
      t += {31'h0, ~ola_q};
    end
    chk("open a steady", t, 32'h0);
    chk("coil b ok", olb_q, 32'h0);
    chk("raised", scale_q > 8'h50, 32'h1);
    repeat (6) begin
      fs <= 1'b1;
      @(posedge clk_i);
      fs <= 1'b0;
      cyc(PER);
    end
    chk("both flags", olb_q, 32'h1);
    rchk("int", ADDR_INT_STATUS, 32'h3, 32'h3, RESP_OKAY);
    wchk(ADDR_INT_STATUS, 32'hF, RESP_OKAY);
    wchk(ADDR_INT_MASK, 32'h0, RESP_OKAY);
    vel <= 23'hC8;
    cyc(2 * PER);
    chk("masked", irq_q, 32'h0);
    chk("flags off", ola_q, 32'h0);
    rchk("int", ADDR_INT_STATUS, 32'h4, 32'h4, RESP_OKAY);
    wchk(ADDR_INT_MASK, 32'h4, RESP_OKAY);
    cyc(3);
    chk("unmasked", irq_q, 32'h1);
    print_verdict();
  end
endmodule : vpc_top_tb
`default_nettype wire
